// File: coipr_regs.sv
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "coipr_defs.svh"
module coipr_regs
    import coipr_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic [5:0] port_latch,
    input wire logic [5:0] port_pins,
    input wire logic [5:0] change_detect_enables,
    output logic [5:0] pullup_enable,
    input wire logic external_irq_pin,
    input wire logic external_tmr_clock_pin,
    input wire logic wdt_clock_tick,
    output logic wdt_prescaled_tick,
    input wire coipr_periph_ev_s periph_ev,
    input wire coipr_ccp_mode_e ccp_mode,
    input wire logic por_event,
    input wire logic brownout_event,
    input wire logic brownout_detect_enable,
    output logic irq_request
);

    // Address match, shared by all decodes
    function automatic logic addr_hit(
        input logic [7:0] a,
        input logic [7:0] ofs
    );
        addr_hit = (a == ofs);
    endfunction : addr_hit

    // Low-bit mask of a 2^n prescale ratio
    function automatic logic [7:0] rate_mask(input logic [3:0] n);
        logic [8:0] t;
        t = 9'h001 << n;
        rate_mask = 8'(t - 9'h001);
    endfunction : rate_mask

    coipr_option_s opt;
    logic global_irq_enable;
    logic periph_irq_enable;
    logic tmr_overflow_irq_enable;
    logic ext_pin_irq_enable;
    logic port_change_irq_enable;
    logic tmr_overflow_flag;
    logic ext_pin_irq_flag;
    logic port_change_flag;
    logic converter_irq_enable;
    logic capcomp_irq_enable;
    logic comparator_irq_enable;
    logic period_match_irq_enable;
    logic t1_overflow_irq_enable;
    logic converter_done_flag;
    logic capcomp_flag;
    logic comparator_change_flag;
    logic period_match_flag;
    logic t1_overflow_flag;
    logic power_on_status_n;
    logic brownout_status_n;
    logic [7:0] tmr_count;
    logic [7:0] prescaler;
    logic [1:0] instr_div;
    logic ext_pin_q;
    logic tclk_pin_q;
    logic cmp_q;
    logic [5:0] port_q;

    logic wr_opt;
    logic wr_ctl;
    logic wr_pie;
    logic wr_pir;
    logic wr_pwr;
    logic wr_tcnt;
    logic ext_edge;
    logic tclk_edge;
    logic instr_tick;
    logic src_tick;
    logic pre_in;
    logic tmr_tick;
    logic tmr_rollover;
    logic port_change;
    logic cmp_change;
    logic capcomp_event;
    logic core_pending;
    logic periph_pending;
    logic [7:0] tmr_mask;
    logic [7:0] wdt_mask;
    logic [7:0] next_rdata;

    // Write strobes per register
    assign wr_opt = reg_write && addr_hit(reg_addr, `COIPR_OFS_OPTION);
    assign wr_ctl = reg_write && addr_hit(reg_addr, `COIPR_OFS_INTCTL);
    assign wr_pie = reg_write && addr_hit(reg_addr, `COIPR_OFS_PIE);
    assign wr_pir = reg_write && addr_hit(reg_addr, `COIPR_OFS_PIR);
    assign wr_pwr = reg_write && addr_hit(reg_addr, `COIPR_OFS_PWR);
    assign wr_tcnt = reg_write && addr_hit(reg_addr, `COIPR_OFS_TCOUNT);

    // Option register, all ones after reset
    always_ff @(posedge clk) begin
        if (reset) begin
            opt <= `COIPR_OPTION_RST;
        end else if (wr_opt) begin
            opt <= reg_wdata;
        end
    end

    // Pull-ups follow the latch unless globally disabled
    always_ff @(posedge clk) begin
        if (reset) begin
            pullup_enable <= 6'h00;
        end else if (opt.pullup_disable_n) begin
            pullup_enable <= 6'h00;
        end else begin
            pullup_enable <= port_latch;
        end
    end

    // Pin history; follows the pin during reset so release sees no edge
    always_ff @(posedge clk) begin
        ext_pin_q <= external_irq_pin;
        tclk_pin_q <= external_tmr_clock_pin;
        cmp_q <= periph_ev.comparator_out;
        port_q <= port_pins;
    end

    // Edge and change detection
    assign ext_edge = opt.ext_irq_edge_select ?
        (external_irq_pin && !ext_pin_q) :
        (!external_irq_pin && ext_pin_q);
    assign tclk_edge = opt.tmr_source_edge_sel ?
        (!external_tmr_clock_pin && tclk_pin_q) :
        (external_tmr_clock_pin && !tclk_pin_q);
    assign port_change = |((port_pins ^ port_q) & change_detect_enables);
    assign cmp_change = periph_ev.comparator_out ^ cmp_q;

    // Instruction clock divider
    always_ff @(posedge clk) begin
        if (reset) begin
            instr_div <= 2'h0;
        end else begin
            instr_div <= instr_div + 2'h1;
        end
    end

    assign instr_tick = (instr_div == `COIPR_INSTR_LAST);
    assign src_tick = opt.tmr_clock_source_sel ? tclk_edge : instr_tick;

    // One prescaler, shared; switching owner mid-count shortens one period
    assign pre_in = opt.prescaler_assign ? wdt_clock_tick : src_tick;
    assign tmr_mask = rate_mask({1'b0, opt.prescale_rate} + 4'h1);
    assign wdt_mask = rate_mask({1'b0, opt.prescale_rate});

    always_ff @(posedge clk) begin
        if (reset) begin
            prescaler <= 8'h00;
        end else if (pre_in) begin
            prescaler <= prescaler + 8'h01;
        end
    end

    // Timer bypasses the prescaler while the watchdog owns it
    assign tmr_tick = opt.prescaler_assign ? src_tick :
        (src_tick && ((prescaler & tmr_mask) == tmr_mask));

    // Prescaled watchdog tick
    always_ff @(posedge clk) begin
        if (reset) begin
            wdt_prescaled_tick <= 1'b0;
        end else begin
            wdt_prescaled_tick <= opt.prescaler_assign && wdt_clock_tick &&
                ((prescaler & wdt_mask) == wdt_mask);
        end
    end

    // Timer count; no reset, software loads it before use
    always_ff @(posedge clk) begin
        if (wr_tcnt) begin
            tmr_count <= reg_wdata;
        end else if (tmr_tick) begin
            tmr_count <= tmr_count + 8'h01;
        end
    end

    assign tmr_rollover = tmr_tick && !wr_tcnt &&
        (tmr_count == `COIPR_TCOUNT_MAX);

    // Core enables
    always_ff @(posedge clk) begin
        if (reset) begin
            global_irq_enable <= 1'b0;
            periph_irq_enable <= 1'b0;
            tmr_overflow_irq_enable <= 1'b0;
            ext_pin_irq_enable <= 1'b0;
            port_change_irq_enable <= 1'b0;
        end else if (wr_ctl) begin
            global_irq_enable <= reg_wdata[`COIPR_B_GLOBAL_EN];
            periph_irq_enable <= reg_wdata[`COIPR_B_PERIPH_EN];
            tmr_overflow_irq_enable <= reg_wdata[`COIPR_B_TMR_EN];
            ext_pin_irq_enable <= reg_wdata[`COIPR_B_EXT_EN];
            port_change_irq_enable <= reg_wdata[`COIPR_B_CHGIE];
        end
    end

    // Core flags; a hardware set beats a software clear
    always_ff @(posedge clk) begin
        if (reset) begin
            tmr_overflow_flag <= 1'b0;
        end else if (tmr_rollover) begin
            tmr_overflow_flag <= 1'b1;
        end else if (wr_ctl) begin
            tmr_overflow_flag <= reg_wdata[`COIPR_B_T0F];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ext_pin_irq_flag <= 1'b0;
        end else if (ext_edge) begin
            ext_pin_irq_flag <= 1'b1;
        end else if (wr_ctl) begin
            ext_pin_irq_flag <= reg_wdata[`COIPR_B_EXT_F];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            port_change_flag <= 1'b0;
        end else if (port_change) begin
            port_change_flag <= 1'b1;
        end else if (wr_ctl) begin
            port_change_flag <= reg_wdata[`COIPR_B_CHGF];
        end
    end

    // Peripheral enables; unimplemented bits never stored
    always_ff @(posedge clk) begin
        if (reset) begin
            converter_irq_enable <= 1'b0;
            capcomp_irq_enable <= 1'b0;
            comparator_irq_enable <= 1'b0;
            period_match_irq_enable <= 1'b0;
            t1_overflow_irq_enable <= 1'b0;
        end else if (wr_pie) begin
            converter_irq_enable <= reg_wdata[`COIPR_B_CONV];
            capcomp_irq_enable <= reg_wdata[`COIPR_B_CAPC];
            comparator_irq_enable <= reg_wdata[`COIPR_B_CMP];
            period_match_irq_enable <= reg_wdata[`COIPR_B_PER];
            t1_overflow_irq_enable <= reg_wdata[`COIPR_B_T1];
        end
    end

    // Converter flag; a new start clears a stale completion
    always_ff @(posedge clk) begin
        if (reset) begin
            converter_done_flag <= 1'b0;
        end else if (periph_ev.converter_done) begin
            converter_done_flag <= 1'b1;
        end else if (periph_ev.converter_start) begin
            converter_done_flag <= 1'b0;
        end else if (wr_pir) begin
            converter_done_flag <= reg_wdata[`COIPR_B_CONV];
        end
    end

    // Capture/compare source depends on mode
    assign capcomp_event =
        ((ccp_mode == COIPR_CAPTURE) && periph_ev.capture_event) ||
        ((ccp_mode == COIPR_COMPARE) && periph_ev.compare_match);

    always_ff @(posedge clk) begin
        if (reset) begin
            capcomp_flag <= 1'b0;
        end else if (capcomp_event) begin
            capcomp_flag <= 1'b1;
        end else if (wr_pir) begin
            capcomp_flag <= reg_wdata[`COIPR_B_CAPC];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            comparator_change_flag <= 1'b0;
        end else if (cmp_change) begin
            comparator_change_flag <= 1'b1;
        end else if (wr_pir) begin
            comparator_change_flag <= reg_wdata[`COIPR_B_CMP];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            period_match_flag <= 1'b0;
        end else if (periph_ev.period_match) begin
            period_match_flag <= 1'b1;
        end else if (wr_pir) begin
            period_match_flag <= reg_wdata[`COIPR_B_PER];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            t1_overflow_flag <= 1'b0;
        end else if (periph_ev.t1_overflow) begin
            t1_overflow_flag <= 1'b1;
        end else if (wr_pir) begin
            t1_overflow_flag <= reg_wdata[`COIPR_B_T1];
        end
    end

    // Power status; the reset event outranks a software write
    always_ff @(posedge clk) begin
        if (reset) begin
            {power_on_status_n, brownout_status_n} <= `COIPR_PWR_RST;
        end else begin
            if (por_event) begin
                power_on_status_n <= 1'b0;
            end else if (wr_pwr) begin
                power_on_status_n <= reg_wdata[`COIPR_B_POR];
            end
            if (brownout_event) begin
                brownout_status_n <= 1'b0;
            end else if (wr_pwr) begin
                brownout_status_n <= reg_wdata[`COIPR_B_BROWNOUT];
            end
        end
    end

    // Interrupt request combination
    assign core_pending =
        (tmr_overflow_flag && tmr_overflow_irq_enable) ||
        (ext_pin_irq_flag && ext_pin_irq_enable) ||
        (port_change_flag && port_change_irq_enable);
    assign periph_pending = periph_irq_enable && (
        (converter_done_flag && converter_irq_enable) ||
        (capcomp_flag && capcomp_irq_enable) ||
        (comparator_change_flag && comparator_irq_enable) ||
        (period_match_flag && period_match_irq_enable) ||
        (t1_overflow_flag && t1_overflow_irq_enable));

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_request <= 1'b0;
        end else begin
            irq_request <= global_irq_enable &&
                (core_pending || periph_pending);
        end
    end

    // Read mux; unmapped and unimplemented bits read zero
    always_comb begin
        next_rdata = 8'h00;
        if (addr_hit(reg_addr, `COIPR_OFS_OPTION)) begin
            next_rdata = opt;
        end else if (addr_hit(reg_addr, `COIPR_OFS_INTCTL)) begin
            next_rdata = {global_irq_enable, periph_irq_enable,
                tmr_overflow_irq_enable, ext_pin_irq_enable,
                port_change_irq_enable, tmr_overflow_flag,
                ext_pin_irq_flag, port_change_flag};
        end else if (addr_hit(reg_addr, `COIPR_OFS_PIE)) begin
            next_rdata = {1'b0, converter_irq_enable, capcomp_irq_enable,
                1'b0, comparator_irq_enable, 1'b0,
                period_match_irq_enable, t1_overflow_irq_enable};
        end else if (addr_hit(reg_addr, `COIPR_OFS_PIR)) begin
            next_rdata = {1'b0, converter_done_flag, capcomp_flag,
                1'b0, comparator_change_flag, 1'b0,
                period_match_flag, t1_overflow_flag};
        end else if (addr_hit(reg_addr, `COIPR_OFS_PWR)) begin
            next_rdata = {6'h00, power_on_status_n,
                brownout_status_n && brownout_detect_enable};
        end else if (addr_hit(reg_addr, `COIPR_OFS_TCOUNT)) begin
            next_rdata = tmr_count;
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Checks
    property p_pullup;
        @(posedge clk) disable iff (reset)
        1 |=> pullup_enable ==
            ($past(opt.pullup_disable_n) ? 6'h00 : $past(port_latch));
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("pull-up enables wrong");

    property p_ext_flag;
        @(posedge clk) disable iff (reset)
        (opt.ext_irq_edge_select && $rose(external_irq_pin)) |=>
            ext_pin_irq_flag;
    endproperty
    a_ext_flag: assert property (p_ext_flag)
        else $error("rising edge lost");

    property p_t0_bypass;
        @(posedge clk) disable iff (reset)
        (opt.prescaler_assign && !opt.tmr_clock_source_sel &&
            instr_tick && !wr_tcnt) |=>
            tmr_count == $past(tmr_count) + 8'h01;
    endproperty
    a_t0_bypass: assert property (p_t0_bypass)
        else $error("timer not 1:1");

    property p_rollover;
        @(posedge clk) disable iff (reset)
        tmr_rollover |=> tmr_overflow_flag && (tmr_count == 8'h00);
    endproperty
    a_rollover: assert property (p_rollover)
        else $error("rollover flag missing");

    property p_port;
        @(posedge clk) disable iff (reset)
        (|((port_pins ^ port_q) & change_detect_enables)) |=>
            port_change_flag;
    endproperty
    a_port: assert property (p_port)
        else $error("port change lost");

    property p_cmp;
        @(posedge clk) disable iff (reset)
        comparator_change_flag && !wr_pir |=> comparator_change_flag;
    endproperty
    a_cmp: assert property (p_cmp)
        else $error("comparator flag dropped");

    property p_gie;
        @(posedge clk) disable iff (reset)
        !global_irq_enable |=> !irq_request;
    endproperty
    a_gie: assert property (p_gie)
        else $error("request with global off");

    property p_brownout;
        @(posedge clk) disable iff (reset)
        (reg_read && addr_hit(reg_addr, `COIPR_OFS_PWR) &&
            !brownout_detect_enable) |=> !reg_rdata[`COIPR_B_BROWNOUT];
    endproperty
    a_brownout: assert property (p_brownout)
        else $error("brown-out bit not zero");

    property p_por;
        @(posedge clk) disable iff (reset)
        por_event |=> !power_on_status_n;
    endproperty
    a_por: assert property (p_por)
        else $error("power-on bit not cleared");

    property p_conv;
        @(posedge clk) disable iff (reset)
        (periph_ev.converter_start && !periph_ev.converter_done) |=>
            !converter_done_flag;
    endproperty
    a_conv: assert property (p_conv)
        else $error("converter flag set while pending");

endmodule : coipr_regs
`default_nettype wire

// File: coipr_defs.svh
`ifndef COIPR_DEFS_SVH
`define COIPR_DEFS_SVH

// Register offsets on the plain register port
`define COIPR_OFS_OPTION 8'h00
`define COIPR_OFS_INTCTL 8'h01
`define COIPR_OFS_PIE 8'h02
`define COIPR_OFS_PIR 8'h03
`define COIPR_OFS_PWR 8'h04
`define COIPR_OFS_TCOUNT 8'h05

// Reset values
`define COIPR_OPTION_RST 8'hFF
`define COIPR_INTCTL_RST 8'h00
`define COIPR_PIE_RST 8'h00
`define COIPR_PIR_RST 8'h00
`define COIPR_PWR_RST 2'h0

// Core control field positions
`define COIPR_B_GLOBAL_EN 7
`define COIPR_B_PERIPH_EN 6
`define COIPR_B_TMR_EN 5
`define COIPR_B_EXT_EN 4
`define COIPR_B_CHGIE 3
`define COIPR_B_T0F 2
`define COIPR_B_EXT_F 1
`define COIPR_B_CHGF 0

// Peripheral enable and flag positions
`define COIPR_B_CONV 6
`define COIPR_B_CAPC 5
`define COIPR_B_CMP 3
`define COIPR_B_PER 1
`define COIPR_B_T1 0

// Power status positions
`define COIPR_B_POR 1
`define COIPR_B_BROWNOUT 0

// Instruction clock is oscillator / 4
`define COIPR_INSTR_LAST 2'h3
`define COIPR_TCOUNT_MAX 8'hFF

`endif

// File: coipr_pkg.sv
`default_nettype none
package coipr_pkg;

    // Timer, pull-up and edge options
    typedef struct packed {
        logic pullup_disable_n;
        logic ext_irq_edge_select;
        logic tmr_clock_source_sel;
        logic tmr_source_edge_sel;
        logic prescaler_assign;
        logic [2:0] prescale_rate;
    } coipr_option_s;

    // Events arriving from peripheral logic
    typedef struct packed {
        logic converter_start;
        logic converter_done;
        logic capture_event;
        logic compare_match;
        logic comparator_out;
        logic period_match;
        logic t1_overflow;
    } coipr_periph_ev_s;

    // Capture/compare unit mode
    typedef enum logic [1:0] {
        COIPR_CAPTURE,
        COIPR_COMPARE,
        COIPR_PWM
    } coipr_ccp_mode_e;

endpackage : coipr_pkg
`default_nettype wire

// File: coipr_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "coipr_defs.svh"
module coipr_regs_tb_top
    import coipr_pkg::*;
;
    logic clk, reset, wr_s, rd_s, xpin, tpin, wtick, wout, irq, por, bo, bo_en, rd_seen;
    logic [7:0] addr, wd, rdata, rv;
    logic [5:0] latch, pins, cde, pu;
    coipr_periph_ev_s pe;
    coipr_ccp_mode_e mode;
    logic [7:0] exp_q[$];
    int mismatches, comparisons, wcount;
    // Event table: input pulse, flag it sets, capture unit mode
    logic [6:0] ev[6] = '{7'h20, 7'h10, 7'h08, 7'h02, 7'h01, 7'h04};
    logic [7:0] fl[6] = '{8'h40, 8'h20, 8'h20, 8'h02, 8'h01, 8'h08};
    coipr_ccp_mode_e md[6] = '{COIPR_CAPTURE, COIPR_CAPTURE, COIPR_COMPARE,
        COIPR_CAPTURE, COIPR_CAPTURE, COIPR_CAPTURE};

    coipr_regs dut (.clk(clk), .reset(reset), .reg_addr(addr), .reg_wdata(wd),
        .reg_write(wr_s), .reg_read(rd_s), .reg_rdata(rdata), .port_latch(latch),
        .port_pins(pins), .change_detect_enables(cde), .pullup_enable(pu),
        .external_irq_pin(xpin), .external_tmr_clock_pin(tpin),
        .wdt_clock_tick(wtick), .wdt_prescaled_tick(wout), .periph_ev(pe),
        .ccp_mode(mode), .por_event(por), .brownout_event(bo),
        .brownout_detect_enable(bo_en), .irq_request(irq));

    // Free-running clock, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] expd);
        comparisons++;
        if (seen !== expd) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, expd);
        end
    endtask : check

    task automatic final_report();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    // Read data stands only in the cycle after the strobe, so sample it there
    always @(posedge clk) begin
        if (rd_seen) begin
            check(rdata, exp_q.pop_front());
        end
        rd_seen <= rd_s;
    end

    // Prescaled watchdog pulses
    always @(posedge clk) begin
        if (wout === 1'b1) begin
            wcount++;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd_s <= 1'b0;
    endtask : rd

    // Comparator level is kept so a later pulse is not a false change
    task automatic pulse(input logic [6:0] v);
        @(posedge clk);
        pe <= v;
        @(posedge clk);
        pe <= v & 7'h04;
        tick(2);
    endtask : pulse

    task automatic tpulses(input int n);
        repeat (n) begin
            @(posedge clk);
            tpin <= 1'b1;
            tick(2);
            tpin <= 1'b0;
            tick(2);
        end
    endtask : tpulses

    // Watchdog: cut a hang short
    initial begin
        tick(30000);
        mismatches++;
        final_report();
    end

    initial begin
        {reset, wr_s, rd_s, xpin, tpin, wtick, por, bo, rd_seen} = '0;
        {addr, wd, latch, pins, cde, pe} = '0;
        bo_en = 1'b1;
        mode = COIPR_CAPTURE;
        reset = 1'b1;
        void'($urandom(36));
        tick(2);
        reset <= 1'b0;
        // Reset values, unmapped place, read-only zero bits
        rd(`COIPR_OFS_OPTION, 8'hFF);
        rd(`COIPR_OFS_INTCTL, 8'h00);
        rd(`COIPR_OFS_PIE, 8'h00);
        rd(`COIPR_OFS_PIR, 8'h00);
        rd(`COIPR_OFS_PWR, 8'h00);
        wr(8'h20, 8'hFF);
        rd(8'h20, 8'h00);
        // Count is unknown after reset; load it before a random option may run it
        wr(`COIPR_OFS_TCOUNT, 8'h00);
        rv = 8'($urandom);
        wr(`COIPR_OFS_OPTION, rv);
        rd(`COIPR_OFS_OPTION, rv);
        wr(`COIPR_OFS_PIE, 8'hFF);
        rd(`COIPR_OFS_PIE, 8'h6B);
        wr(`COIPR_OFS_PIE, 8'h00);
        // Timer prescale from the pin, exact multiples hide the counter phase
        for (int r = 0; r < 8; r++) begin
            wr(`COIPR_OFS_OPTION, 8'hA0 | 8'(r));
            wr(`COIPR_OFS_TCOUNT, 8'h00);
            tpulses(4 << r);
            rd(`COIPR_OFS_TCOUNT, 8'h02);
        end
        wr(`COIPR_OFS_OPTION, 8'hA8);
        wr(`COIPR_OFS_TCOUNT, 8'h00);
        tpulses(5);
        rd(`COIPR_OFS_TCOUNT, 8'h05);
        for (int r = 0; r < 8; r++) begin
            wr(`COIPR_OFS_OPTION, 8'hA8 | 8'(r));
            wcount = 0;
            repeat (4 << r) begin
                @(posedge clk);
                wtick <= 1'b1;
                @(posedge clk);
                wtick <= 1'b0;
            end
            tick(3);
            check(8'(wcount), 8'h04);
        end
        // Falling pin edge counts, rising does not
        wr(`COIPR_OFS_OPTION, 8'hB8);
        wr(`COIPR_OFS_TCOUNT, 8'h00);
        tpin <= 1'b1;
        tick(4);
        rd(`COIPR_OFS_TCOUNT, 8'h00);
        tpin <= 1'b0;
        tick(4);
        rd(`COIPR_OFS_TCOUNT, 8'h01);
        // Internal clock rollover
        wr(`COIPR_OFS_INTCTL, 8'h00);
        wr(`COIPR_OFS_OPTION, 8'h88);
        wr(`COIPR_OFS_TCOUNT, 8'hFF);
        tick(8);
        rd(`COIPR_OFS_INTCTL, 8'h04);
        tick(20);
        rd(`COIPR_OFS_INTCTL, 8'h04);
        // Pull-ups, external edge, global gating
        wr(`COIPR_OFS_OPTION, 8'h68);
        wr(`COIPR_OFS_INTCTL, 8'h90);
        latch <= 6'($urandom);
        tick(3);
        check({2'b00, pu}, {2'b00, latch});
        xpin <= 1'b1;
        tick(3);
        check({7'h00, irq}, 8'h01);
        rd(`COIPR_OFS_INTCTL, 8'h92);
        wr(`COIPR_OFS_INTCTL, 8'h12);
        tick(2);
        check({7'h00, irq}, 8'h00);
        wr(`COIPR_OFS_INTCTL, 8'h00);
        xpin <= 1'b0;
        tick(3);
        rd(`COIPR_OFS_INTCTL, 8'h00);
        wr(`COIPR_OFS_OPTION, 8'hA8);
        tick(2);
        check({2'b00, pu}, 8'h00);
        xpin <= 1'b1;
        tick(3);
        rd(`COIPR_OFS_INTCTL, 8'h00);
        xpin <= 1'b0;
        tick(3);
        rd(`COIPR_OFS_INTCTL, 8'h02);
        // Change detect only on enabled pins
        wr(`COIPR_OFS_INTCTL, 8'h00);
        cde <= 6'h01;
        pins <= 6'h02;
        tick(3);
        rd(`COIPR_OFS_INTCTL, 8'h00);
        pins <= 6'h03;
        tick(3);
        rd(`COIPR_OFS_INTCTL, 8'h01);
        // Every peripheral flag, all enables off
        for (int i = 0; i < 6; i++) begin
            wr(`COIPR_OFS_PIR, 8'h00);
            mode <= md[i];
            pulse(ev[i]);
            rd(`COIPR_OFS_PIR, fl[i]);
        end
        wr(`COIPR_OFS_PIR, 8'h00);
        mode <= COIPR_PWM;
        pulse(7'h1C);
        rd(`COIPR_OFS_PIR, 8'h00);
        pulse(7'h24);
        rd(`COIPR_OFS_PIR, 8'h40);
        pulse(7'h44);
        rd(`COIPR_OFS_PIR, 8'h00);
        // Peripheral gating of the request
        wr(`COIPR_OFS_INTCTL, 8'h80);
        wr(`COIPR_OFS_PIE, 8'h01);
        pulse(7'h05);
        check({7'h00, irq}, 8'h00);
        wr(`COIPR_OFS_INTCTL, 8'hC0);
        tick(2);
        check({7'h00, irq}, 8'h01);
        wr(`COIPR_OFS_PIE, 8'h00);
        tick(2);
        check({7'h00, irq}, 8'h00);
        // Power status bits
        wr(`COIPR_OFS_PWR, 8'hFF);
        rd(`COIPR_OFS_PWR, 8'h03);
        @(posedge clk) por <= 1'b1;
        @(posedge clk) por <= 1'b0;
        rd(`COIPR_OFS_PWR, 8'h01);
        wr(`COIPR_OFS_PWR, 8'h03);
        @(posedge clk) bo <= 1'b1;
        @(posedge clk) bo <= 1'b0;
        rd(`COIPR_OFS_PWR, 8'h02);
        wr(`COIPR_OFS_PWR, 8'h03);
        bo_en <= 1'b0;
        tick(2);
        rd(`COIPR_OFS_PWR, 8'h02);
        tick(3);
        final_report();
    end
endmodule : coipr_regs_tb_top
`default_nettype wire
